// ### hdl/gcr_pkg.sv
`default_nettype none
package gcr_pkg;
  // frame geometry
  localparam int          FRAME_BITS  = 32;
  localparam logic [31:0] INIT_RESP   = 32'h0000_0001; // first answer
  // register addresses (9-bit)
  localparam logic [8:0]  QUAD_ADDR   = 9'h008;  // quadrature_level, RO
  localparam logic [8:0]  FAULT_ADDR  = 9'h00A;  // fault_flags, read-clear
  localparam logic [8:0]  TRIM_ADDR   = 9'h00C;  // offset_trim_register, RW
  localparam logic [8:0]  PID_ADDR    = 9'h00E;  // part id, RO
  localparam logic [15:0] PID_VALUE   = 16'h5A5A; // arbitrary value
  localparam logic [15:0] TRIM_RESET  = 16'h0000;
  localparam logic [15:0] ROM_VALUE   = 16'hC35A; // arbitrary known pattern
  // command opcodes, bits 31:29
  localparam logic [2:0]  OP_READ     = 3'h4;
  localparam logic [2:0]  OP_WRITE    = 3'h2;
  // response opcodes and fixed nibble
  localparam logic [2:0]  RSP_READ    = 3'h2;
  localparam logic [2:0]  RSP_WRITE   = 3'h1;
  localparam logic [2:0]  RSP_ERROR   = 3'h0;
  localparam logic [3:0]  RSP_FIXED   = 4'hE;
  localparam logic [2:0]  MODULE_SEL  = 3'h0;
  // response_kind codes
  localparam logic [1:0]  KIND_ERR    = 2'h0;
  localparam logic [1:0]  KIND_VALID  = 2'h1;
  localparam logic [1:0]  KIND_SELF   = 2'h2;
  localparam logic [1:0]  KIND_RW     = 2'h3;
  // fault_flags bit positions
  localparam int FB_CHK  = 1;
  localparam int FB_CST  = 2;
  localparam int FB_PWR  = 3;
  localparam int FB_POR  = 4;
  localparam int FB_NVM  = 5;
  localparam int FB_QUAD = 6;
  localparam int FB_PLL  = 7;
  localparam int FB_UV   = 8;
  localparam int FB_OV   = 9;
  localparam int FB_AMP  = 10;
  localparam int FB_FAIL = 11;
  localparam logic [15:0] CARRY_MASK = 16'h00FE; // bits sent in frames
  // detection thresholds in LSB
  localparam logic [15:0] QUAD_LIMIT = 16'h1000; // 4096
  localparam logic [15:0] CST_WARN   = 16'h0200; // 512
  localparam logic [15:0] CST_GROSS  = 16'h0740; // 1856
  // timing
  localparam int CLK_MHZ        = 125;
  localparam int WRITE_BUSY_MS  = 17;
  localparam int NVM_PERIOD_US  = 50;
  localparam int POR_PERIOD_US  = 1;
  localparam int WRITE_BUSY_CYC = WRITE_BUSY_MS * 1000 * CLK_MHZ;
  localparam int NVM_PERIOD_CYC = NVM_PERIOD_US * CLK_MHZ;
  localparam int POR_PERIOD_CYC = POR_PERIOD_US * CLK_MHZ;
endpackage
`default_nettype wire

// ### hdl/gcr_sync.sv
`timescale 1ns/10ps
`default_nettype none
// two-stage synchroniser for pin levels
module gcr_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_b_i,
  // levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;  // first stage, read only by sync_o

  // both stages, idle value under reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      meta_reg <= RST_VAL;
      sync_o   <= RST_VAL;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ### hdl/gcr_sticky.sv
`timescale 1ns/10ps
`default_nettype none
// one sticky fault flag: set wins over read-clear
module gcr_sticky (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  // condition and clear
  input  wire logic cond_i,
  input  wire logic clear_i,
  output logic      flag_o
);
  logic flag_next;  // next flag value

  // a live condition re-sets the flag in the same cycle as a clear
  always_comb begin
    flag_next = cond_i | (flag_o & ~clear_i);
  end

  // flag storage
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= flag_next;
    end
  end
endmodule
`default_nettype wire

// ### hdl/gcr_core.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// (R1) snapshot at select, answer next frame
// (R2) echo sequence_tag into response
// (R3) module_select always returned as 000
// (R4) address ignored in sensor data requests
// (R5) write response echoes written word
// (R6) frame error on bit count or parity
// (R7) sensor request error gives error response
// (R8) response_kind 00 err 01 ok 10 self 11 rw
// (R9) lock loss forces response_kind 00
// (R10) host sends odd parity over command
// (R11) odd parity upper half and full response
// (R12) request_error on bad command or register
// (R13) write busy 17 ms, repeat write gets data_unavailable
// (R14) host waits 10 us before read; the bench host waits 200 clocks, 1.6 us
// (R15) fault flags sticky until read, reassert
// (R16) faults in sensor response and 0x0A
// (R17) quadrature above 4096 sets quadrature fault
// (R18) checksum every 50 us sets checksum_fault
// (R19) startup value vs rom every 1 us
// (R20) supply_fault on over or undervoltage
// (R21) selftest beyond 512 flags, 1856 kind 00
// (R22) fault_inject forces every fault flag
// (R23) exactly 32 clocks, mode 0
// (R24) first answer is 0x00000001
// (R25) response shifted msb first, fixed layouts
module gcr_core #(
  parameter int unsigned WRITE_BUSY_CYC = gcr_pkg::WRITE_BUSY_CYC,
  parameter int unsigned NVM_PERIOD_CYC = gcr_pkg::NVM_PERIOD_CYC
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  // serial link pins
  input  wire logic        sclk_i,
  input  wire logic        cs_b_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  output logic             miso_oe_o,
  // sensor side, same clock
  input  wire logic [15:0] rate_data_i,
  input  wire logic [15:0] quad_level_i,
  input  wire logic [15:0] selftest_dev_i,
  input  wire logic        lock_loss_i,
  input  wire logic        amp_fail_i,
  input  wire logic        overvoltage_i,
  input  wire logic        undervoltage_i,
  input  wire logic [15:0] nvm_sum_i,
  input  wire logic [15:0] nvm_ref_i,
  input  wire logic [15:0] startup_copy_i,
  // control out
  output logic             fault_inject_o,
  output logic [15:0]      offset_trim_o,
  output logic             write_busy_o
);
  // synchronised pins and edge history
  logic        sclk_s, cs_b_s, mosi_s;
  logic        sclk_d_reg, cs_d_reg;
  logic        sclk_rise, sclk_fall, cs_fall, cs_rise;
  // frame state
  logic [31:0] rx_reg;          // command shifted in
  logic [31:0] tx_reg;          // response shifted out
  logic [5:0]  bit_cnt_reg;     // saturates at 33
  // snapshot taken at select
  logic [15:0] snap_rate_reg, snap_quad_reg, snap_flt_reg;
  // fault state
  logic [15:0] flt_q, cond, clr_vec, keep_vec;
  logic        nvm_err_reg, por_err_reg;
  logic [31:0] nvm_cnt_reg, por_cnt_reg, busy_cnt_reg;
  // decode of the finished command
  logic        frame_err, is_sensor, is_read, is_write;
  logic        reg_exists, reg_writable, req_err, du_err;
  logic        sensor_ok, write_go, carry_clr;
  logic [2:0]  seq_tag;
  logic [8:0]  addr;
  logic [15:0] rd_data;
  logic [1:0]  kind;
  logic [31:0] resp_next;

  // sample pins; cs idles high so it resets to 1
  gcr_sync #(.WIDTH(3), .RST_VAL(3'b010)) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .async_i   ({sclk_i, cs_b_i, mosi_i}),
    .sync_o    ({sclk_s, cs_b_s, mosi_s})
  );

  // edge history on the synchronised levels
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      sclk_d_reg <= 1'b0;
      cs_d_reg   <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_d_reg   <= cs_b_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_reg & ~cs_b_s;
  assign sclk_fall = ~sclk_s & sclk_d_reg & ~cs_b_s;
  assign cs_fall   = ~cs_b_s & cs_d_reg;
  assign cs_rise   = cs_b_s & ~cs_d_reg;

  // receive: mode 0 samples on rising clock, count rising edges up to 33
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rx_reg      <= 32'h0000_0000;
      bit_cnt_reg <= 6'h00;
    end else if (cs_fall) begin
      bit_cnt_reg <= 6'h00;
    end else if (sclk_rise) begin
      rx_reg <= {rx_reg[30:0], mosi_s};
      // saturate so a long frame never wraps back to 32
      if (bit_cnt_reg != 6'h21) begin
        bit_cnt_reg <= bit_cnt_reg + 6'h01; // R23
      end
    end
  end

  // snapshot of live data at select
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      snap_rate_reg <= 16'h0000;
      snap_quad_reg <= 16'h0000;
      snap_flt_reg  <= 16'h0000;
    end else if (cs_fall) begin
      snap_rate_reg <= rate_data_i;  // R1
      snap_quad_reg <= quad_level_i; // R1
      snap_flt_reg  <= flt_q;        // R1
    end
  end

  // command decode at end of frame
  always_comb begin
    frame_err = (bit_cnt_reg != 6'(gcr_pkg::FRAME_BITS)) | ~(^rx_reg); // R6 R10
    is_sensor = rx_reg[29];
    is_read   = rx_reg[31:29] == gcr_pkg::OP_READ;
    is_write  = rx_reg[31:29] == gcr_pkg::OP_WRITE;
    seq_tag   = {rx_reg[28], rx_reg[31:30]}; // R2
    addr      = rx_reg[25:17];               // R4
    reg_exists   = (addr == gcr_pkg::QUAD_ADDR) |
                   (addr == gcr_pkg::FAULT_ADDR) |
                   (addr == gcr_pkg::TRIM_ADDR) |
                   (addr == gcr_pkg::PID_ADDR);
    reg_writable = addr == gcr_pkg::TRIM_ADDR;
    // invalid opcode, missing register, or read-only target
    req_err = ~is_sensor & (~(is_read | is_write) | ~reg_exists |
              (is_write & ~reg_writable)); // R12
    du_err    = is_write & ~req_err & (busy_cnt_reg != 32'h0000_0000); // R13
    sensor_ok = is_sensor & ~frame_err;
    write_go  = is_write & ~frame_err & ~req_err & ~du_err;
    // fault bits leave the device in sensor and error frames
    carry_clr = sensor_ok | frame_err | req_err | du_err;
  end

  // read data mux, address used only for read and write
  always_comb begin
    unique case (addr)
      gcr_pkg::QUAD_ADDR:  rd_data = snap_quad_reg;
      gcr_pkg::FAULT_ADDR: rd_data = snap_flt_reg; // R16
      gcr_pkg::TRIM_ADDR:  rd_data = offset_trim_o;
      gcr_pkg::PID_ADDR:   rd_data = gcr_pkg::PID_VALUE;
      default:             rd_data = 16'h0000;
    endcase
  end

  // response_kind: inject marks self-test, fail marks error
  always_comb begin
    if (fault_inject_o) begin
      kind = gcr_pkg::KIND_SELF; // R8 R22
    end else if (snap_flt_reg[gcr_pkg::FB_FAIL]) begin
      kind = gcr_pkg::KIND_ERR;  // R9 R21
    end else begin
      kind = gcr_pkg::KIND_VALID; // R8
    end
  end

  // assemble next response, then fill both parity bits
  always_comb begin
    resp_next = 32'h0000_0000;
    if (sensor_ok) begin
      resp_next[31:29] = seq_tag;       // R2
      resp_next[27:26] = kind;          // R8
      resp_next[25:10] = snap_rate_reg;
      resp_next[7:1]   = snap_flt_reg[7:1]; // R16
    end else begin
      resp_next[27:24] = gcr_pkg::RSP_FIXED;
      resp_next[23:21] = gcr_pkg::MODULE_SEL; // R3
      if (frame_err | req_err | du_err) begin
        // sensor requests with errors also land here
        resp_next[31:29] = gcr_pkg::RSP_ERROR; // R7
        resp_next[18]    = frame_err;          // R6
        resp_next[17]    = req_err & ~frame_err; // R12
        resp_next[16]    = du_err & ~frame_err;  // R13
        resp_next[7:1]   = snap_flt_reg[7:1];
      end else if (is_write) begin
        resp_next[31:29] = gcr_pkg::RSP_WRITE;
        resp_next[20:5]  = rx_reg[16:1]; // R5
      end else begin
        resp_next[31:29] = gcr_pkg::RSP_READ;
        resp_next[20:5]  = rd_data;
      end
    end
    resp_next[28] = ~^resp_next[31:16]; // R11
    resp_next[0]  = ~^resp_next[31:1];  // R11
  end

  // transmit: load at deselect, shift msb first on falling clock
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      tx_reg <= gcr_pkg::INIT_RESP; // R24
    end else if (cs_rise) begin
      tx_reg <= resp_next; // R1
    end else if (sclk_fall) begin
      tx_reg <= {tx_reg[30:0], 1'b0}; // R25
    end
  end

  assign miso_o = tx_reg[31]; // R25

  // drive miso only while selected
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      miso_oe_o <= 1'b0;
    end else begin
      miso_oe_o <= ~cs_b_s;
    end
  end

  // inject follows the last good sensor request
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      fault_inject_o <= 1'b0;
    end else if (cs_rise && sensor_ok) begin
      fault_inject_o <= rx_reg[1]; // R22
    end
  end

  // write engine: commit at once, then hold busy for the full time
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      offset_trim_o <= gcr_pkg::TRIM_RESET;
      busy_cnt_reg  <= 32'h0000_0000;
    end else if (cs_rise && write_go) begin
      offset_trim_o <= rx_reg[16:1];
      busy_cnt_reg  <= WRITE_BUSY_CYC; // R13
    end else if (busy_cnt_reg != 32'h0000_0000) begin
      busy_cnt_reg <= busy_cnt_reg - 32'h0000_0001; // R13
    end
  end

  // busy flag, registered so the output is a flip-flop
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      write_busy_o <= 1'b0;
    end else begin
      write_busy_o <= (cs_rise && write_go) ||
                      (busy_cnt_reg > 32'h0000_0001);
    end
  end

  // periodic checksum and startup-copy checks
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      nvm_cnt_reg <= 32'h0000_0000;
      por_cnt_reg <= 32'h0000_0000;
      nvm_err_reg <= 1'b0;
      por_err_reg <= 1'b0;
    end else begin
      if (nvm_cnt_reg >= NVM_PERIOD_CYC - 1) begin
        nvm_cnt_reg <= 32'h0000_0000;
        nvm_err_reg <= nvm_sum_i != nvm_ref_i; // R18
      end else begin
        nvm_cnt_reg <= nvm_cnt_reg + 32'h0000_0001;
      end
      if (por_cnt_reg >= 32'(gcr_pkg::POR_PERIOD_CYC - 1)) begin
        por_cnt_reg <= 32'h0000_0000;
        por_err_reg <= startup_copy_i != gcr_pkg::ROM_VALUE; // R19
      end else begin
        por_cnt_reg <= por_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // fault conditions; inject forces every one of them
  always_comb begin
    cond = 16'h0000;
    cond[gcr_pkg::FB_PLL]  = lock_loss_i;
    cond[gcr_pkg::FB_QUAD] = quad_level_i > gcr_pkg::QUAD_LIMIT; // R17
    cond[gcr_pkg::FB_NVM]  = nvm_err_reg;  // R18
    cond[gcr_pkg::FB_POR]  = por_err_reg;  // R19
    cond[gcr_pkg::FB_PWR]  = overvoltage_i | undervoltage_i; // R20
    cond[gcr_pkg::FB_UV]   = undervoltage_i;
    cond[gcr_pkg::FB_OV]   = overvoltage_i;
    cond[gcr_pkg::FB_AMP]  = amp_fail_i;
    // amplitude loss shares the self-test position
    cond[gcr_pkg::FB_CST]  = (selftest_dev_i > gcr_pkg::CST_WARN) |
                             amp_fail_i; // R21
    cond[gcr_pkg::FB_FAIL] = lock_loss_i |
                             (selftest_dev_i > gcr_pkg::CST_GROSS); // R9 R21
    cond[gcr_pkg::FB_CHK]  = fault_inject_o;
    if (fault_inject_o) begin
      cond = cond | 16'h0FFE; // R22
    end
  end

  // only bits that were actually sent are cleared
  always_comb begin
    clr_vec = 16'h0000;
    if (cs_rise && carry_clr) begin
      clr_vec = snap_flt_reg & gcr_pkg::CARRY_MASK; // R15
    end
    if (cs_rise && is_read && !frame_err && !req_err &&
        addr == gcr_pkg::FAULT_ADDR) begin
      clr_vec = snap_flt_reg; // R15 R16
    end
  end

  // flags that must survive this edge
  assign keep_vec = flt_q & ~clr_vec; // R15

  // sticky flag bank
  for (genvar i = 0; i < 16; i++) begin : g_flt
    gcr_sticky u_flag (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .cond_i    (cond[i]),
      .clear_i   (clr_vec[i]),
      .flag_o    (flt_q[i])
    );
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  property p_init_resp;
    $rose(rst_b_i) |-> tx_reg == gcr_pkg::INIT_RESP;
  endproperty
  a_init_resp: assert property (p_init_resp) // R24
    else $error("first response word wrong");

  property p_seq_echo;
    cs_rise && sensor_ok |=> tx_reg[31:29] == $past(seq_tag);
  endproperty
  a_seq_echo: assert property (p_seq_echo) // R2
    else $error("sequence tag not echoed");

  property p_module_sel;
    cs_rise && !sensor_ok |=> tx_reg[23:21] == 3'b000 && tx_reg[27:24] == 4'hE;
  endproperty
  a_module_sel: assert property (p_module_sel) // R3
    else $error("module select field not zero");

  property p_parity;
    cs_rise |=> (^tx_reg[31:16]) && (^tx_reg);
  endproperty
  a_parity: assert property (p_parity) // R11
    else $error("response parity not odd");

  property p_frame_err;
    cs_rise && frame_err |=> tx_reg[31:29] == 3'b000 && tx_reg[18];
  endproperty
  a_frame_err: assert property (p_frame_err) // R6
    else $error("frame error not reported");

  property p_busy_du;
    cs_rise && is_write && !frame_err && !req_err && busy_cnt_reg != 0
      |=> tx_reg[16] && $stable(offset_trim_o);
  endproperty
  a_busy_du: assert property (p_busy_du) // R13
    else $error("write during busy not refused");

  property p_write_echo;
    cs_rise && write_go |=> tx_reg[20:5] == $past(rx_reg[16:1]) ##1
      write_busy_o [*3];
  endproperty
  a_write_echo: assert property (p_write_echo) // R5
    else $error("write echo or busy wrong");

  property p_sticky;
    keep_vec != 16'h0000 |=>
      (flt_q & $past(keep_vec)) == $past(keep_vec);
  endproperty
  a_sticky: assert property (p_sticky) // R15
    else $error("fault flag dropped without read");

  property p_quad;
    quad_level_i > gcr_pkg::QUAD_LIMIT |=> flt_q[gcr_pkg::FB_QUAD];
  endproperty
  a_quad: assert property (p_quad) // R17
    else $error("quadrature fault missing");

  property p_supply;
    overvoltage_i || undervoltage_i |=> flt_q[gcr_pkg::FB_PWR];
  endproperty
  a_supply: assert property (p_supply) // R20
    else $error("supply fault missing");

  property p_lock_kind;
    cs_rise && sensor_ok && !fault_inject_o &&
      snap_flt_reg[gcr_pkg::FB_PLL] |=> tx_reg[27:26] == 2'b00;
  endproperty
  a_lock_kind: assert property (p_lock_kind) // R9
    else $error("lock loss did not mark error kind");
endmodule
`default_nettype wire

// ### bench/gcr_host.sv
`timescale 1ns/10ps
`default_nettype none
// host master model: mode 0, 64 ns link clock, clock parked low
module gcr_host (
  // clock
  input  wire logic clk_sys_i,
  // link pins
  output logic      sclk_o,
  output logic      cs_b_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  // idle levels from time zero
  initial begin
    sclk_o = 1'b0;
    cs_b_o = 1'b1;
    mosi_o = 1'b0;
  end
  // odd parity over all 32 command bits, don't-care bits included
  function automatic logic [31:0] seal(input logic [31:0] c);
    return {c[31:1], ~^c[31:1]};
  endfunction
  // one frame of n clocks; only the first 32 answer bits are kept
  task automatic xfer(input logic [31:0] c, input int n,
                      output logic [31:0] r);
    r = '0;
    @(posedge clk_sys_i);
    cs_b_o <= 1'b0;
    mosi_o <= c[31];
    // data moves on the fall, both sides sample on the rise
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk_sys_i);
      sclk_o <= 1'b1;
      if (i < 32) r = {r[30:0], miso_i}; // msb first
      repeat (4) @(posedge clk_sys_i);
      sclk_o <= 1'b0;
      mosi_o <= (i < 31) ? c[30-i] : ~mosi_o;
    end
    repeat (4) @(posedge clk_sys_i);
    cs_b_o <= 1'b1;
    // a released line must not keep showing its last bit
    mosi_o <= ~mosi_o;
    // long gap so the periodic fault checks settle between frames
    repeat (200) @(posedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// self-checking bench: a queue model predicts every answer
module testbench;
  localparam int unsigned BUSY = 600; // shortened write time
  localparam int unsigned NVMP = 20;  // shortened checksum period
  // fault scenarios: lock amp ov uv nvm copy quad gross warn
  localparam logic [8:0] FT [11] = '{9'h000, 9'h100, 9'h080, 9'h040,
    9'h020, 9'h010, 9'h008, 9'h004, 9'h001, 9'h002, 9'h000};
  // clock, reset, link and sensor side
  logic        clk_sys_i, rst_b_i, sclk, cs_b, mosi, miso, miso_oe;
  logic        lock, amp, ov, uv, inj_o, busy_o;
  logic [15:0] rate, quad, dev, sum, ref_v, copy, trim_o, wd;
  wire  logic  miso_w;
  // model state and bookkeeping
  logic [15:0] st, trim_m;
  logic        inj_m, busy_m;
  logic [31:0] q[$];
  logic [8:0]  at[5];
  int          fails, tests_run;
  // released data line is pulled up
  assign miso_w = miso_oe ? miso : 1'b1;
  gcr_core #(.WRITE_BUSY_CYC(BUSY), .NVM_PERIOD_CYC(NVMP)) gcr_core_i (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .sclk_i(sclk),
    .cs_b_i(cs_b), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
    .rate_data_i(rate), .quad_level_i(quad), .selftest_dev_i(dev),
    .lock_loss_i(lock), .amp_fail_i(amp), .overvoltage_i(ov),
    .undervoltage_i(uv), .nvm_sum_i(sum), .nvm_ref_i(ref_v),
    .startup_copy_i(copy), .fault_inject_o(inj_o),
    .offset_trim_o(trim_o), .write_busy_o(busy_o));
  gcr_host host_i (.clk_sys_i(clk_sys_i), .sclk_o(sclk), .cs_b_o(cs_b),
    .mosi_o(mosi), .miso_i(miso_w));
  // free-running system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // conditions that the sticky flags follow
  function automatic logic [15:0] cnd();
    logic [15:0] c;
    c = '0;
    c[2] = (dev > gcr_pkg::CST_WARN) | amp;
    c[3] = ov | uv;
    c[4] = copy != gcr_pkg::ROM_VALUE;
    c[5] = sum != ref_v;
    c[6] = quad > gcr_pkg::QUAD_LIMIT;
    c[7] = lock;
    c[8] = uv;
    c[9] = ov;
    c[10] = amp;
    c[11] = lock | (dev > gcr_pkg::CST_GROSS);
    return inj_m ? 16'h0FFE : c;
  endfunction
  // both response parity bits, odd
  function automatic logic [31:0] par(input logic [31:0] r);
    r[28] = ~^{r[31:29], r[27:16]};
    r[0] = ~^r[31:1];
    return r;
  endfunction
  // read or write answer shape
  function automatic logic [31:0] rwf(input logic [2:0] o,
                                      input logic [15:0] d);
    return par({o, 1'b0, 4'hE, 3'h0, d, 5'h00});
  endfunction
  // error answer shape: frame, request, unavailable bits
  function automatic logic [31:0] erf(input logic [2:0] e,
                                      input logic [15:0] f);
    return par({3'h0, 1'b0, 4'hE, 3'h0, 2'b00, e, 8'h00, f[7:1], 1'b0});
  endfunction
  // predict the answer to one frame and advance model state
  task automatic model(input logic [31:0] c, input int n);
    logic [15:0] rep, clr;
    logic [31:0] r;
    logic [2:0]  e;
    logic [1:0]  k;
    rep = st | cnd();
    clr = 16'h00FE;
    e = 3'h0;
    k = rep[11] ? 2'h0 : 2'h1;
    if (inj_m) k = 2'h2;
    if (n != 32 || ^c == 1'b0) e = 3'h4;
    else if (c[29])
      r = par({c[28], c[31:30], 1'b0, k, rate, 2'b00, rep[7:1], 1'b0});
    else if (c[31:29] == gcr_pkg::OP_READ) begin
      clr = 16'h0000;
      case (c[25:17])
        gcr_pkg::QUAD_ADDR:  r = rwf(gcr_pkg::RSP_READ, quad);
        gcr_pkg::TRIM_ADDR:  r = rwf(gcr_pkg::RSP_READ, trim_m);
        gcr_pkg::PID_ADDR:   r = rwf(gcr_pkg::RSP_READ, gcr_pkg::PID_VALUE);
        gcr_pkg::FAULT_ADDR: r = rwf(gcr_pkg::RSP_READ, rep);
        default:             e = 3'h2;
      endcase
      if (c[25:17] == gcr_pkg::FAULT_ADDR) clr = 16'hFFFF;
    end else if (c[31:29] == gcr_pkg::OP_WRITE && busy_m &&
                 c[25:17] == gcr_pkg::TRIM_ADDR) e = 3'h1;
    else if (c[31:29] == gcr_pkg::OP_WRITE &&
             c[25:17] == gcr_pkg::TRIM_ADDR) begin
      trim_m = c[16:1];
      busy_m = 1'b1;
      clr = 16'h0000;
      r = rwf(gcr_pkg::RSP_WRITE, c[16:1]);
    end else e = 3'h2;
    // any failed request answers in the error shape
    if (e != 3'h0) begin
      r = erf(e, rep);
      clr = 16'h00FE;
    end
    st = (rep & ~clr) | cnd();
    if (e == 3'h0 && c[29]) inj_m = c[1];
    q.push_back(r);
  endtask
  // compare tasks, one per kind of result
  task automatic chk32(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic chk16(input string nm, input logic [15:0] x,
                       input logic [15:0] g);
    tests_run++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask
  // one exchange: check the previous answer, queue this one
  task automatic go(input logic [31:0] c, input int n);
    logic [31:0] got, x;
    host_i.xfer(c, n, got);
    x = q.pop_front();
    chk32("response", (n < 32) ? x >> (32 - n) : x, got);
    model(c, n);
  endtask
  // command builders; sensor don't-care bits are random
  function automatic logic [31:0] sreq(input logic [2:0] s,
                                       input logic k);
    logic [31:0] c;
    c = $urandom;
    c[31:28] = {s[1:0], 1'b1, s[2]};
    c[1] = k;
    return host_i.seal(c);
  endfunction
  function automatic logic [31:0] rreq(input logic [2:0] o,
                                       input logic [8:0] a,
                                       input logic [15:0] d);
    return host_i.seal({o, 3'h0, a, d, 1'b0});
  endfunction
  // single closing point of the run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // watchdog, well above the expected run length
  initial begin
    repeat (70000) @(posedge clk_sys_i);
    fails++;
    give_verdict();
  end
  // main sequence
  initial begin
    fails = 0;
    tests_run = 0;
    {lock, amp, ov, uv} = 4'h0;
    {rate, quad, dev, sum, ref_v, wd} = '0;
    copy = gcr_pkg::ROM_VALUE;
    st = '0;
    trim_m = gcr_pkg::TRIM_RESET;
    {inj_m, busy_m} = 2'b00;
    at = '{gcr_pkg::QUAD_ADDR, gcr_pkg::TRIM_ADDR, gcr_pkg::PID_ADDR,
           gcr_pkg::FAULT_ADDR, 9'h1FF};
    q.push_back(gcr_pkg::INIT_RESP);
    rst_b_i = 1'b0;
    void'($urandom(99339));
    repeat (8) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk16("trim", gcr_pkg::TRIM_RESET, trim_o);
    // every sequence tag, fresh rate each frame
    for (int s = 0; s < 8; s++) begin
      rate <= 16'($urandom);
      @(posedge clk_sys_i);
      go(sreq(s[2:0], 1'b0), 32);
    end
    quad <= 16'($urandom_range(4095));
    @(posedge clk_sys_i);
    foreach (at[i]) go(rreq(gcr_pkg::OP_READ, at[i], 16'h0000), 32);
    go(rreq(3'h0, gcr_pkg::TRIM_ADDR, 16'h0000), 32);
    go(rreq(3'h6, gcr_pkg::TRIM_ADDR, 16'h0000), 32);
    go(rreq(gcr_pkg::OP_WRITE, gcr_pkg::QUAD_ADDR, 16'h1234), 32);
    // write, then a refused write inside the busy time
    wd = 16'($urandom);
    go(rreq(gcr_pkg::OP_WRITE, gcr_pkg::TRIM_ADDR, wd), 32);
    chk16("busy", 16'h0001, {15'h0000, busy_o});
    go(rreq(gcr_pkg::OP_WRITE, gcr_pkg::TRIM_ADDR, ~wd), 32);
    chk16("trim", wd, trim_o);
    repeat (1250) @(posedge clk_sys_i);
    busy_m = 1'b0;
    chk16("busy", 16'h0000, {15'h0000, busy_o});
    go(rreq(gcr_pkg::OP_READ, gcr_pkg::TRIM_ADDR, 16'h0000), 32);
    // parity slip, short and long frames
    go(sreq(3'h5, 1'b0) ^ 32'h0000_0004, 32);
    go(sreq(3'h2, 1'b0), 31);
    go(sreq(3'h3, 1'b0), 33);
    go(sreq(3'h6, 1'b0), 32);
    // each fault source in turn, quad and warn at and just past their limit
    for (int t = 0; t < 11; t++) begin
      {lock, amp, ov, uv} <= FT[t][8:5];
      sum <= {15'h0000, FT[t][4]};
      copy <= gcr_pkg::ROM_VALUE ^ {15'h0000, FT[t][3]};
      quad <= FT[t][2] ? 16'h1001 : 16'h1000;
      dev <= FT[t][1] ? 16'h0741 : (FT[t][0] ? 16'h0201 : 16'h0200);
      repeat (200) @(posedge clk_sys_i);
      go(sreq(t[2:0], 1'b0), 32);
      go(rreq(gcr_pkg::OP_READ, gcr_pkg::FAULT_ADDR, 16'h0000), 32);
    end
    // short supply glitch must stay visible until read
    ov <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    ov <= 1'b0;
    st = st | 16'h0208;
    go(sreq(3'h1, 1'b0), 32);
    go(sreq(3'h2, 1'b0), 32);
    go(rreq(gcr_pkg::OP_READ, gcr_pkg::FAULT_ADDR, 16'h0000), 32);
    // fault injection on and off again
    go(sreq(3'h3, 1'b1), 32);
    chk16("inject", 16'h0001, {15'h0000, inj_o});
    go(sreq(3'h4, 1'b1), 32);
    go(sreq(3'h5, 1'b0), 32);
    go(sreq(3'h6, 1'b0), 32);
    go(rreq(gcr_pkg::OP_READ, gcr_pkg::FAULT_ADDR, 16'h0000), 32);
    go(rreq(gcr_pkg::OP_READ, gcr_pkg::FAULT_ADDR, 16'h0000), 32);
    go(sreq(3'h7, 1'b0), 32);
    give_verdict();
  end
endmodule
`default_nettype wire
